// [hdl/fcs_pkg.sv]
/*
 * Shared constants and types for the flash command sequencer host.
 * Assumes a 100 MHz pclk and a 512K x 8 flash on an asynchronous parallel bus.
 */
package fcs_pkg;
	localparam int CLK_NS = 10;
	// Software register map, one word each
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam int CTRL_QSEL_BIT = 8;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_AUTOSEL = 4;
	localparam int ST_WIN = 5;
	localparam int ST_SUSP = 6;
	localparam int ST_ERASING = 7;
	localparam int ST_RDATA_LSB = 8;
	localparam logic [18:0] RST_ADDR = 19'h00000;
	localparam logic [7:0] RST_DATA = 8'h00;
	// Command bytes and unlock addresses
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_PROG = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_SUSP = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [18:0] ADDR_UNLOCK1 = 19'h05555;
	localparam logic [18:0] ADDR_UNLOCK2 = 19'h02aaa;
	localparam logic [18:0] ADDR_ANY = 19'h00000;
	localparam logic [3:0] QUERY_NIBBLE = 4'h2;
	// Status bit positions on the flash data bus
	localparam int POLL_STATUS_BIT = 7;
	localparam int TIME_LIMIT_FAIL_BIT = 5;
	// Pin timing, rounded up to whole cycles
	localparam int WE_PULSE_NS = 50;
	localparam int SETUP_NS = 20;
	localparam int READ_NS = 150;
	localparam int RECOV_NS = 20;
	localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;
	// Sector erase window, a longest time so rounded down
	localparam int WIN_US = 80;
	localparam int WIN_CYC = WIN_US * 1000 / CLK_NS;

	typedef enum logic [3:0] {OP_READ, OP_RESET, OP_AUTOSEL, OP_QUERY, OP_PROG, OP_CHIP,
		OP_SECT, OP_SECT_ADD, OP_SUSP, OP_RESUME, OP_EPOLL} fcs_op_t;

	typedef struct packed {
		logic wr;
		logic [18:0] addr;
		logic [7:0] data;
	} fcs_bus_t;
endpackage : fcs_pkg

// [hdl/fcs_win_timer.sv]
/*
 * Sector erase window timer: open for CYC cycles after the last restart.
 * Assumes restart and stop are single-cycle pulses in the pclk domain.
 */
module fcs_win_timer #(
	parameter int CYC = fcs_pkg::WIN_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic stop,
	output logic open
);
	localparam int W = $clog2(CYC + 1);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Restart reloads the full window; stop closes it at once
	always_comb begin
		cnt_nxt = cnt_r;
		if (stop)
			cnt_nxt = '0;
		else if (restart)
			cnt_nxt = W'(CYC);
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign open = (cnt_r != '0);
endmodule : fcs_win_timer

// [hdl/fcs_bus_cycle.sv]
/*
 * One asynchronous flash bus cycle, write or read, driven from pclk.
 * Assumes the flash data bus is resolved outside from flash_dq_o and flash_dq_oe.
 */
module fcs_bus_cycle (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input fcs_pkg::fcs_bus_t req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic [18:0] flash_addr,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_i,
	output logic flash_cs_n,
	output logic flash_oe_n,
	output logic flash_we_n
);
	typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_RECOV} fcs_bstate_t;
	fcs_bstate_t st_r, st_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt;
	logic [18:0] addr_r, addr_nxt;
	logic [7:0] dq_r, dq_nxt, rd_r, rd_nxt;
	logic cs_n_r, cs_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, rv_r, rv_nxt;

	// Strobe lies inside chip select so address and data hold on both edges
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		dq_nxt = dq_r;
		rd_nxt = rd_r;
		cs_n_nxt = cs_n_r;
		oe_n_nxt = oe_n_r;
		we_n_nxt = we_n_r;
		rv_nxt = 1'b0;
		unique case (st_r)
			B_IDLE: if (req_valid) begin
				st_nxt = B_SETUP;
				wr_nxt = req.wr;
				addr_nxt = req.addr;
				dq_nxt = req.data;
				cs_n_nxt = 1'b0;
				cnt_nxt = 5'(fcs_pkg::SETUP_CYC - 1);
			end
			B_SETUP: if (cnt_r != '0) begin
				cnt_nxt = cnt_r - 1'b1;
			end else begin
				st_nxt = B_STROBE;
				we_n_nxt = !wr_r;
				oe_n_nxt = wr_r;
				cnt_nxt = wr_r ? 5'(fcs_pkg::WE_PULSE_CYC - 1) : 5'(fcs_pkg::READ_CYC - 1);
			end
			B_STROBE: if (cnt_r != '0) begin
				cnt_nxt = cnt_r - 1'b1;
			end else begin
				st_nxt = B_RECOV;
				we_n_nxt = 1'b1; // Rising strobe latches data, starts the operation
				oe_n_nxt = 1'b1;
				rd_nxt = flash_dq_i;
				rv_nxt = !wr_r;
				cnt_nxt = 5'(fcs_pkg::RECOV_CYC - 1);
			end
			B_RECOV: begin
				cs_n_nxt = 1'b1;
				if (cnt_r != '0)
					cnt_nxt = cnt_r - 1'b1;
				else
					st_nxt = B_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= B_IDLE;
			cnt_r <= '0;
			wr_r <= 1'b0;
			addr_r <= fcs_pkg::RST_ADDR;
			dq_r <= fcs_pkg::RST_DATA;
			rd_r <= fcs_pkg::RST_DATA;
			cs_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			rv_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			dq_r <= dq_nxt;
			rd_r <= rd_nxt;
			cs_n_r <= cs_n_nxt;
			oe_n_r <= oe_n_nxt;
			we_n_r <= we_n_nxt;
			rv_r <= rv_nxt;
		end
	end

	assign req_ready = (st_r == B_IDLE);
	assign rsp_valid = rv_r;
	assign rsp_data = rd_r;
	assign flash_addr = addr_r;
	assign flash_dq_o = dq_r;
	assign flash_dq_oe = wr_r && !cs_n_r; // Drive only while writing
	assign flash_cs_n = cs_n_r;
	assign flash_oe_n = oe_n_r;
	assign flash_we_n = we_n_r;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_we_inside_cs: assert property (!flash_we_n |-> !flash_cs_n && flash_oe_n && flash_dq_oe)
		else $error("write strobe outside chip select or with output enable");
	a_we_pulse_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
		else $error("write strobe width wrong");
endmodule : fcs_bus_cycle

// [hdl/fcs_ctrl.sv]
/*
 * Flash command sequencer host: APB register slave plus command and polling engine.
 * Assumes one flash on the parallel pins, synchronous inputs, and software via APB.
 */
// Added by the designer: the APB interface to the registers and the register offsets.
// Functional notes
// - Autoselect stays until read/reset command; host tracks and keeps it so.
// - Byte program is four writes: two unlocks, set-up, address with data.
// - Program done when polled bit equals written bit at program address.
// - Sector erase is six writes, last is 30H inside the target sector.
// - Further sector erase commands only inside the 80us restartable window.
// - Reset during erase leaves sectors undefined; software reissues the erase.
// - Sector erase done when poll bit reads 1 at an erasing-sector address.
// - Suspend-program only to non-suspended sectors; poll at program address. Host refuses only the six-write erase's sector, not added sectors.
module fcs_ctrl #(
	parameter int WIN_CYC = fcs_pkg::WIN_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [18:0] flash_addr,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [7:0] flash_dq_i,
	output logic flash_cs_n,
	output logic flash_oe_n,
	output logic flash_we_n
);
	typedef enum logic [1:0] {S_IDLE, S_CMD, S_READ, S_POLL} fcs_state_t;
	fcs_state_t st_r, st_nxt;
	fcs_pkg::fcs_op_t op_r, op_nxt, op_sel;
	logic [2:0] step_r, step_nxt, last_step;
	logic [18:0] addr_r, addr_nxt, poll_addr_r, poll_addr_nxt;
	logic [7:0] data_r, data_nxt, rdata_r, rdata_nxt;
	logic qsel_r, qsel_nxt, exp_r, exp_nxt, retry_r, retry_nxt;
	logic done_r, done_nxt, fail_r, fail_nxt, refused_r, refused_nxt;
	logic autosel_r, autosel_nxt, susp_r, susp_nxt, erasing_r, erasing_nxt;
	logic [2:0] erase_sec_r, erase_sec_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic wr_acc, start, legal, req_valid, req_ready, rsp_valid, issue;
	logic win_open, win_restart, win_stop;
	logic [7:0] rsp_data;
	fcs_pkg::fcs_bus_t req;

	// Writes after a multi-write prefix; single-write commands have one step
	function automatic logic [2:0] cmd_last(input fcs_pkg::fcs_op_t op);
		unique case (op)
			fcs_pkg::OP_AUTOSEL: return 3'd2;
			fcs_pkg::OP_PROG: return 3'd3;
			fcs_pkg::OP_CHIP, fcs_pkg::OP_SECT: return 3'd5;
			default: return 3'd0;
		endcase
	endfunction

	// Address and data of each write of a command sequence
	function automatic fcs_pkg::fcs_bus_t cmd_step(input fcs_pkg::fcs_op_t op, input logic [2:0] s,
		input logic [18:0] a, input logic [7:0] d);
		fcs_pkg::fcs_bus_t b;
		b.wr = 1'b1;
		b.addr = fcs_pkg::ADDR_UNLOCK1;
		b.data = fcs_pkg::CMD_UNLOCK1;
		if (op == fcs_pkg::OP_RESET) begin
			b.addr = fcs_pkg::ADDR_ANY;
			b.data = fcs_pkg::CMD_RESET;
		end else if (op == fcs_pkg::OP_SECT_ADD) begin
			b.addr = a;
			b.data = fcs_pkg::CMD_SECT;
		end else if (op == fcs_pkg::OP_SUSP) begin
			b.addr = fcs_pkg::ADDR_ANY;
			b.data = fcs_pkg::CMD_SUSP;
		end else if (op == fcs_pkg::OP_RESUME) begin
			b.addr = fcs_pkg::ADDR_ANY;
			b.data = fcs_pkg::CMD_RESUME;
		end else if (s == 3'd1 || s == 3'd4) begin
			b.addr = fcs_pkg::ADDR_UNLOCK2;
			b.data = fcs_pkg::CMD_UNLOCK2;
		end else if (s == 3'd2) begin
			b.data = (op == fcs_pkg::OP_AUTOSEL) ? fcs_pkg::CMD_AUTOSEL :
				(op == fcs_pkg::OP_PROG) ? fcs_pkg::CMD_PROG : fcs_pkg::CMD_ERASE_SETUP;
		end else if (s == 3'd3 && op == fcs_pkg::OP_PROG) begin
			b.addr = a;
			b.data = d;
		end else if (s == 3'd5) begin
			b.addr = (op == fcs_pkg::OP_SECT) ? a : fcs_pkg::ADDR_UNLOCK1;
			b.data = (op == fcs_pkg::OP_SECT) ? fcs_pkg::CMD_SECT : fcs_pkg::CMD_CHIP;
		end
		return b;
	endfunction

	assign wr_acc = psel && penable && pwrite;
	assign start = wr_acc && paddr == fcs_pkg::OFF_CTRL;
	assign op_sel = fcs_pkg::fcs_op_t'(pwdata[3:0]);
	assign pready = 1'b1; // Zero wait states
	assign pslverr = psel && penable && !(paddr inside {fcs_pkg::OFF_CTRL, fcs_pkg::OFF_ADDR,
		fcs_pkg::OFF_DATA, fcs_pkg::OFF_STAT});
	assign prdata = prdata_r;

	// Which orders the flash can take now; anything else is refused, not sent
	always_comb begin
		legal = (st_r == S_IDLE) && op_sel <= fcs_pkg::OP_EPOLL;
		if (autosel_r && !(op_sel inside {fcs_pkg::OP_RESET, fcs_pkg::OP_QUERY, fcs_pkg::OP_READ}))
			legal = 1'b0;
		if (susp_r && !(op_sel inside {fcs_pkg::OP_RESUME, fcs_pkg::OP_PROG, fcs_pkg::OP_READ,
			fcs_pkg::OP_EPOLL, fcs_pkg::OP_RESET}))
			legal = 1'b0;
		if (susp_r && op_sel == fcs_pkg::OP_PROG && addr_r[18:16] == erase_sec_r)
			legal = 1'b0;
		if (erasing_r && !susp_r && !(op_sel inside {fcs_pkg::OP_SECT_ADD, fcs_pkg::OP_SUSP,
			fcs_pkg::OP_READ, fcs_pkg::OP_EPOLL, fcs_pkg::OP_RESET}))
			legal = 1'b0;
		if (op_sel == fcs_pkg::OP_SECT_ADD && !win_open)
			legal = 1'b0;
		if ((op_sel == fcs_pkg::OP_SUSP && (!erasing_r || susp_r)) || (op_sel == fcs_pkg::OP_RESUME && !susp_r))
			legal = 1'b0;
	end

	// Engine: issue command writes, reads and polls, then update flash mode tracking
	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		step_nxt = step_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		qsel_nxt = qsel_r;
		poll_addr_nxt = poll_addr_r;
		exp_nxt = exp_r;
		retry_nxt = retry_r;
		rdata_nxt = rdata_r;
		done_nxt = done_r;
		fail_nxt = fail_r;
		refused_nxt = refused_r;
		autosel_nxt = autosel_r;
		susp_nxt = susp_r;
		erasing_nxt = erasing_r;
		erase_sec_nxt = erase_sec_r;
		win_restart = 1'b0;
		win_stop = 1'b0;
		req_valid = 1'b0;
		req = cmd_step(op_r, step_r, addr_r, data_r);
		if (wr_acc && paddr == fcs_pkg::OFF_ADDR && st_r == S_IDLE)
			addr_nxt = pwdata[18:0];
		if (wr_acc && paddr == fcs_pkg::OFF_DATA && st_r == S_IDLE)
			data_nxt = pwdata[7:0];
		if (start) begin
			refused_nxt = !legal;
			if (legal) begin
				op_nxt = op_sel;
				qsel_nxt = pwdata[fcs_pkg::CTRL_QSEL_BIT];
				step_nxt = '0;
				done_nxt = 1'b0;
				fail_nxt = 1'b0;
				retry_nxt = 1'b0;
				st_nxt = (op_sel == fcs_pkg::OP_READ || op_sel == fcs_pkg::OP_QUERY) ? S_READ :
					(op_sel == fcs_pkg::OP_EPOLL) ? S_POLL : S_CMD;
				poll_addr_nxt = addr_r;
				exp_nxt = (op_sel == fcs_pkg::OP_PROG) ? data_r[fcs_pkg::POLL_STATUS_BIT] : 1'b1;
				if (op_sel == fcs_pkg::OP_SUSP)
					poll_addr_nxt = {erase_sec_r, 16'h0000};
			end
		end
		unique case (st_r)
			S_IDLE: ;
			S_CMD: begin
				req_valid = 1'b1;
				if (issue && (op_r == fcs_pkg::OP_SECT_ADD || (op_r == fcs_pkg::OP_SECT && step_r == 3'd5)))
					win_restart = 1'b1;
				if (issue && op_r == fcs_pkg::OP_SUSP)
					win_stop = 1'b1;
				if (issue) begin
					step_nxt = step_r + 1'b1;
					if (step_r == cmd_last(op_r)) begin
						st_nxt = (op_r inside {fcs_pkg::OP_PROG, fcs_pkg::OP_CHIP, fcs_pkg::OP_SUSP}) ? S_POLL : S_IDLE;
						done_nxt = !(op_r inside {fcs_pkg::OP_PROG, fcs_pkg::OP_CHIP, fcs_pkg::OP_SUSP});
						unique case (op_r)
							fcs_pkg::OP_AUTOSEL: autosel_nxt = 1'b1;
							fcs_pkg::OP_RESET: begin
								autosel_nxt = 1'b0;
								susp_nxt = 1'b0;
								erasing_nxt = 1'b0;
							end
							fcs_pkg::OP_SECT: begin
								erasing_nxt = 1'b1;
								erase_sec_nxt = addr_r[18:16];
							end
							fcs_pkg::OP_RESUME: susp_nxt = 1'b0;
							default: ;
						endcase
					end
				end
			end
			S_READ: begin
				req_valid = 1'b1;
				req.wr = 1'b0;
				req.data = fcs_pkg::RST_DATA;
				req.addr = (op_r == fcs_pkg::OP_QUERY) ?
					{addr_r[18:16], 9'h000, qsel_r, 2'b00, fcs_pkg::QUERY_NIBBLE} : addr_r;
				if (rsp_valid) begin
					rdata_nxt = rsp_data;
					done_nxt = 1'b1;
					st_nxt = S_IDLE;
				end
			end
			S_POLL: begin
				req_valid = !retry_r || !rsp_valid;
				req.wr = 1'b0;
				req.data = fcs_pkg::RST_DATA;
				req.addr = poll_addr_r;
				if (rsp_valid) begin
					rdata_nxt = rsp_data;
					if (rsp_data[fcs_pkg::POLL_STATUS_BIT] == exp_r) begin
						st_nxt = S_IDLE;
						done_nxt = 1'b1;
						if (op_r == fcs_pkg::OP_SUSP)
							susp_nxt = 1'b1;
						else if (op_r == fcs_pkg::OP_EPOLL)
							erasing_nxt = 1'b0;
					end else if (retry_r) begin
						st_nxt = S_IDLE;
						done_nxt = 1'b1;
						fail_nxt = 1'b1;
					end else if (rsp_data[fcs_pkg::TIME_LIMIT_FAIL_BIT]) begin
						retry_nxt = 1'b1; // Poll bit may lag the fail bit, read once more
					end
				end
			end
		endcase
		prdata_nxt = '0;
		if (psel && !penable)
			unique case (paddr)
				fcs_pkg::OFF_CTRL: prdata_nxt = {23'h0, qsel_r, 4'h0, op_r};
				fcs_pkg::OFF_ADDR: prdata_nxt = {13'h0, addr_r};
				fcs_pkg::OFF_DATA: prdata_nxt = {24'h0, data_r};
				fcs_pkg::OFF_STAT: prdata_nxt = {16'h0, rdata_r, erasing_r, susp_r, win_open, autosel_r,
					refused_r, fail_r, done_r, st_r != S_IDLE};
				default: prdata_nxt = '0;
			endcase
	end

	assign issue = req_valid && req_ready;

	// Reset drops all tracking; an erase cut short must be issued again by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= S_IDLE;
			op_r <= fcs_pkg::OP_READ;
			step_r <= '0;
			addr_r <= fcs_pkg::RST_ADDR;
			data_r <= fcs_pkg::RST_DATA;
			qsel_r <= 1'b0;
			poll_addr_r <= fcs_pkg::RST_ADDR;
			exp_r <= 1'b0;
			retry_r <= 1'b0;
			rdata_r <= fcs_pkg::RST_DATA;
			done_r <= 1'b0;
			fail_r <= 1'b0;
			refused_r <= 1'b0;
			autosel_r <= 1'b0;
			susp_r <= 1'b0;
			erasing_r <= 1'b0;
			erase_sec_r <= '0;
			prdata_r <= '0;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			step_r <= step_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			qsel_r <= qsel_nxt;
			poll_addr_r <= poll_addr_nxt;
			exp_r <= exp_nxt;
			retry_r <= retry_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
			fail_r <= fail_nxt;
			refused_r <= refused_nxt;
			autosel_r <= autosel_nxt;
			susp_r <= susp_nxt;
			erasing_r <= erasing_nxt;
			erase_sec_r <= erase_sec_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Window timer counts from the last sector erase command write
	fcs_win_timer #(.CYC(WIN_CYC)) u_win (
		.pclk(pclk),
		.presetn(presetn),
		.restart(win_restart),
		.stop(win_stop),
		.open(win_open)
	);

	// Pin sequencer for one write or read at a time
	fcs_bus_cycle u_bus (
		.pclk(pclk),
		.presetn(presetn),
		.req_valid(req_valid),
		.req(req),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_data(rsp_data),
		.flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe(flash_dq_oe),
		.flash_dq_i(flash_dq_i),
		.flash_cs_n(flash_cs_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n)
	);

	assign last_step = cmd_last(op_r);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_autosel_hold: assert property (autosel_r && !(st_r == S_CMD && op_r == fcs_pkg::OP_RESET) |=> autosel_r)
		else $error("autoselect tracking dropped without reset command");
	a_prog_four_writes: assert property (st_r == S_CMD && op_r == fcs_pkg::OP_PROG |-> step_r <= 3'd3)
		else $error("byte program issued more than four writes");
	a_prog_last_write: assert property (issue && op_r == fcs_pkg::OP_PROG && step_r == 3'd3
		|-> req.addr == addr_r && req.data == data_r ##1 st_r == S_POLL)
		else $error("program data write wrong or not followed by polling");
	a_unlock_first: assert property (issue && step_r == 3'd0 && last_step != 3'd0
		|-> req.addr == fcs_pkg::ADDR_UNLOCK1 && req.data == fcs_pkg::CMD_UNLOCK1)
		else $error("command sequence does not open with first unlock");
	a_poll_done: assert property (st_r == S_POLL && rsp_valid && rsp_data[7] == exp_r
		|=> st_r == S_IDLE && done_r && !fail_r)
		else $error("matching poll did not complete the operation");
	a_sect_last_write: assert property (issue && op_r == fcs_pkg::OP_SECT && step_r == 3'd5
		|-> req.data == fcs_pkg::CMD_SECT && req.addr == addr_r ##1 erasing_r && win_open)
		else $error("sector erase command wrong or window not opened");
	a_add_window: assert property (start && op_sel == fcs_pkg::OP_SECT_ADD && !win_open
		|=> refused_r && op_r == $past(op_r))
		else $error("sector erase accepted after window closed");
	a_erase_expect: assert property (st_r == S_POLL && op_r != fcs_pkg::OP_PROG |-> exp_r)
		else $error("erase poll expects poll bit low");
	a_susp_prog_sector: assert property (st_r == S_CMD && op_r == fcs_pkg::OP_PROG && susp_r
		|-> addr_r[18:16] != erase_sec_r)
		else $error("program sent to the suspended sector");
	c_prog_done: cover property (st_r == S_POLL && op_r == fcs_pkg::OP_PROG ##1 st_r == S_IDLE && done_r);
	c_sect_add: cover property (issue && op_r == fcs_pkg::OP_SECT_ADD);
	c_suspended: cover property (!susp_r ##1 susp_r);
endmodule : fcs_ctrl

// [bench/fcs_flash_model.sv]
/* Behavioural flash partner: command decoder, status bits, sparse array.
   Assumes the bench resolves the data bus and the host drives all strobes. */
module fcs_flash_model #(
	parameter int PROG_NS = 500,
	parameter int WIN_NS = 2000,
	parameter int ERASE_NS = 4000,
	parameter logic [7:0] PROT = 8'h04
) (
	input wire logic [18:0] addr,
	input wire logic [7:0] dq,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	output logic [7:0] q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [logic [18:0]];
	logic [18:0] la, pa;
	logic [7:0] pd, sel = 8'h00, last = 8'h00;
	logic tog = 1'b0, sp = 1'b0;
	int mode = 0, step = 0, cnt = 0, ecnt = 0; // 0 read 1 query 2 prog 3 window 4 erase 5 suspend 6 chip
	// Read value by mode
	function automatic logic [7:0] rd(input logic [18:0] a);
		case (mode)
			1: return {7'h00, PROT[a[18:16]] & ~a[6]};
			2: return {~pd[7], tog, 6'h00};
			3: return {1'b0, tog, 6'h00};
			4, 6: return {1'b0, tog, 6'h08};
			5: if (sel[a[18:16]]) return {5'h11, tog, 2'h0};
		endcase
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction : rd
	// One command write; program and chip erase ignore all writes, sector erase ignores all but suspend
	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		if (mode == 2 || mode == 6 || (mode == 4 && d != 8'hb0)) return;
		if (step == 3) begin pa = a; pd = d; mode = 2; cnt = PROG_NS / 5; step = 0; return; end
		if (d == 8'hb0 && (mode == 3 || mode == 4)) begin
			ecnt = mode == 3 ? ERASE_NS / 5 : cnt; cnt = 0; mode = 5; sp = 1'b1; return; end
		if (mode == 5 && d == 8'h30 && step == 0) begin mode = 4; cnt = ecnt; sp = 1'b0; return; end
		if (mode == 3 && d == 8'h30) begin sel[a[18:16]] = 1'b1; cnt = WIN_NS / 5; return; end
		if (mode == 3) begin mode = 0; sel = 8'h00; cnt = 0; end
		if (d == 8'hf0 && mode != 5) begin mode = 0; step = 0; return; end
		if (a[14:0] == 15'h5555 && d == 8'haa && (step == 0 || step == 4)) step++;
		else if (a[14:0] == 15'h2aaa && d == 8'h55 && (step == 1 || step == 5)) step++;
		else if (step == 2 && d == 8'ha0) step = 3;
		else if (step == 2 && d == 8'h80 && mode != 5) step = 4;
		else if (step == 2 && d == 8'h90 && mode != 5) begin mode = 1; step = 0; end
		else if (step == 6 && d == 8'h10) begin mode = 6; cnt = ERASE_NS / 5; step = 0; end
		else if (step == 6 && d == 8'h30) begin
			sel = 8'h00; sel[a[18:16]] = 1'b1; mode = 3; cnt = WIN_NS / 5; step = 0; end
		else step = 0;
	endtask : wr
	// Address on strobe fall, data and decode on rise
	always @(negedge we_n) la = addr;
	always @(posedge we_n) if (!cs_n) wr(la, dq);
	// End of read toggles status bits; released bus shows the complement
	always @(posedge oe_n) begin tog = ~tog; last = q; end
	// Internal timers and bus output in 5 ns steps, offset so they never race a pclk edge
	initial #2 forever #5 begin
		if (cnt > 1 && mode != 5) cnt--;
		else if (cnt == 1) begin
			cnt = 0;
			case (mode)
				2: begin mem[pa] = pd; mode = sp ? 5 : 0; end
				3: begin mode = 4; cnt = ERASE_NS / 5; end
				4: begin foreach (mem[k]) if (sel[k[18:16]]) mem[k] = 8'hff; sel = 8'h00; mode = 0; end
				default: begin mem.delete(); mode = 0; end
			endcase
		end
		q = (!cs_n && !oe_n) ? rd(addr) : ~last;
	end
endmodule : fcs_flash_model

// [bench/tb_fcs_ctrl.sv]
/* Bench for the flash command sequencer host: APB driver, flash model, scenarios.
   Assumes the package register map and a 100 MHz pclk. */
module tb_fcs_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0] paddr = 8'h00, dq_o, fq;
	logic [31:0] pwdata = 32'h0, prdata, st;
	logic pready, pslverr, dq_oe, cs_n, oe_n, we_n;
	logic [18:0] faddr;
	wire [7:0] dq = dq_oe ? dq_o : fq; // Resolved data bus
	int mismatches = 0, check_count = 0;
	fcs_ctrl #(.WIN_CYC(200)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(faddr),
		.flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq), .flash_cs_n(cs_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
	fcs_flash_model #(.WIN_NS(2000)) flash (.addr(faddr), .dq(dq), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .q(fq));
	// 100 MHz clock
	initial forever #5 pclk = ~pclk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// One APB transfer; an idle edge follows so strobes never change twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin mismatches++; report_and_stop(); end
		st = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Load address and data, start an op, poll until idle
	task automatic run(input logic [31:0] ctrl, input logic [18:0] a, input logic [7:0] d);
		apb(1'b1, fcs_pkg::OFF_ADDR, {13'h0, a});
		apb(1'b1, fcs_pkg::OFF_DATA, {24'h0, d});
		apb(1'b1, fcs_pkg::OFF_CTRL, ctrl);
		for (int i = 0; i < 4000; i++) begin
			apb(1'b0, fcs_pkg::OFF_STAT, 32'h0);
			if (st[fcs_pkg::ST_BUSY] === 1'b0) return;
		end
		mismatches++;
		report_and_stop();
	endtask : run
	task automatic t_reset;
		apb(1'b0, fcs_pkg::OFF_STAT, 32'h0);
		check(st[7:0], 8'h00);
		check({7'h0, err}, 8'h00);
	endtask : t_reset
	task automatic t_prog;
		run(32'h4, 19'h10005, 8'h5a);
		check(st[7:0], 8'h02);
		check(st[15:8], 8'h5a);
		run(32'h4, 19'h70001, 8'ha5);
		check(st[7:0], 8'h02);
		run(32'h0, 19'h10005, 8'h00);
		check(st[15:8], 8'h5a);
	endtask : t_prog
	task automatic t_autosel;
		run(32'h2, 19'h0, 8'h00);
		check({7'h0, st[4]}, 8'h01);
		run(32'h3, 19'h20000, 8'h00);
		check(st[15:8], 8'h01);
		run(32'h103, 19'h20000, 8'h00);
		check(st[15:8], 8'h00);
		run(32'h3, 19'h00000, 8'h00);
		check(st[15:8], 8'h00);
		run(32'h4, 19'h10006, 8'h11);
		check({7'h0, st[3]}, 8'h01);
		run(32'h1, 19'h0, 8'h00);
		check({7'h0, st[4]}, 8'h00);
	endtask : t_autosel
	task automatic t_erase;
		run(32'h4, 19'h30000, 8'h12);
		run(32'h6, 19'h30000, 8'h00);
		check({6'h0, st[7], st[5]}, 8'h03);
		run(32'h7, 19'h40000, 8'h00);
		check({6'h0, st[7], st[5]}, 8'h03);
		run(32'h8, 19'h0, 8'h00);
		check({5'h0, st[7:5]}, 8'h06);
		run(32'h0, 19'h10005, 8'h00);
		check(st[15:8], 8'h5a);
		run(32'h4, 19'h50000, 8'h3c);
		check(st[15:8], 8'h3c);
		run(32'h9, 19'h0, 8'h00);
		check({6'h0, st[7:6]}, 8'h02);
		run(32'ha, 19'h30000, 8'h00);
		check({st[15:8]}, 8'hff);
		run(32'h0, 19'h40000, 8'h00);
		check(st[15:8], 8'hff);
		run(32'h0, 19'h70001, 8'h00);
		check(st[15:8], 8'ha5);
	endtask : t_erase
	task automatic t_misc;
		run(32'h8, 19'h0, 8'h00);
		check({7'h0, st[3]}, 8'h01);
		run(32'hb, 19'h0, 8'h00);
		check({7'h0, st[3]}, 8'h01);
		run(32'h7, 19'h40000, 8'h00);
		check({7'h0, st[3]}, 8'h01);
		apb(1'b0, 8'h10, 32'h0);
		check({7'h0, err}, 8'h01);
	endtask : t_misc
	task automatic t_chip;
		run(32'h5, 19'h0, 8'h00);
		check({6'h0, st[2:1]}, 8'h01);
		run(32'h0, 19'h10005, 8'h00);
		check(st[15:8], 8'hff);
		// Reset inside an erase window drops all tracking
		run(32'h6, 19'h60000, 8'h00);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, fcs_pkg::OFF_STAT, 32'h0);
		check(st[7:0], 8'h00);
	endtask : t_chip
	// Reset for 12 cycles, then the scenarios in order
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_prog();
		t_autosel();
		t_erase();
		t_misc();
		t_chip();
		report_and_stop();
	end
endmodule : tb_fcs_ctrl
